//--- rtl/code_lock_consts.vh
`ifndef CODE_LOCK_CONSTS_VH
`define CODE_LOCK_CONSTS_VH

// signature byte locations in the programming address space
`define SIG_ADDR_MAKER       16'h0030
`define SIG_ADDR_SITE        16'h0031
`define SIG_ADDR_PART        16'h0060

// neutral identity values, arbitrary
`define SIG_VAL_MAKER        8'h5a
`define SIG_VAL_SITE         8'h3c
`define SIG_VAL_PART         8'h7e

// protection level codes (level n is code n-1)
`define LVL_1                2'h0
`define LVL_2                2'h1
`define LVL_3                2'h2
`define LVL_4                2'h3

// internal program memory size in bytes
`define INT_MEM_BYTES        17'h04000

// encryption table
`define ENC_DEPTH            32
`define ENC_IDX_W            5

// register port offsets
`define REG_STATUS           4'h0
`define REG_FLAGS            4'h1
`define REG_CTRL             4'h2
`define REG_PROG_REJ_CNT     4'h3
`define REG_VFY_REJ_CNT      4'h4
`define REG_CODE_TABLE_READ_INSTRUCTION_REJ_CNT     4'h5
`define REG_EXT_REJ_CNT      4'h6
`define REG_LAST_ADDR_LO     4'h7
`define REG_LAST_ADDR_HI     4'h8

// status register fields
`define ST_LEVEL_LSB         0
`define ST_EA_BIT            2
`define ST_ENC_BIT           3
`define ST_UNDEF_BIT         4

// sticky flag fields
`define FL_PROG_REJ          0
`define FL_VFY_REJ           1
`define FL_CODE_TABLE_READ_INSTRUCTION_REJ          2
`define FL_EXT_REJ           3

// control fields
`define CTRL_CNT_CLR         0
`define CTRL_CNT_EN          1
`define CTRL_RESET_VAL       8'h02

`endif

//--- rtl/sync_two_stage.v
`timescale 1ns/100ps
module sync_two_stage #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk,
  input  wire             rst,
  // data
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;

  // first stage is read only by the second
  always @(posedge mclk) begin
    if (rst) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- rtl/encryption_table.v
`timescale 1ns/100ps
`include "code_lock_consts.vh"
module encryption_table #(
  parameter DEPTH = `ENC_DEPTH,
  parameter IDX_W = `ENC_IDX_W
) (
  // clock
  input  wire             mclk,
  // table load
  input  wire             load_en,
  input  wire [IDX_W-1:0] load_idx,
  input  wire [7:0]       load_data,
  // scrambling
  input  wire             enc_active,
  input  wire [IDX_W-1:0] sel_idx,
  input  wire [7:0]       plain_in,
  output wire [7:0]       scrambled
);

  reg  [7:0] table_q [0:DEPTH-1];
  wire [7:0] key;

  // no read port: the key only ever leaves mixed with a code byte
  always @(posedge mclk) begin
    if (load_en) begin
      table_q[load_idx] <= load_data;
    end
  end

  assign key       = table_q[sel_idx];
  assign scrambled = enc_active ? ~(plain_in ^ key) : plain_in;

endmodule

//--- rtl/code_memory_lock_and_verify.v
`timescale 1ns/100ps
`include "code_lock_consts.vh"
module code_memory_lock_and_verify #(
  parameter ADDR_W   = 16,
  parameter CNT_W    = 8,
  parameter SIG_MAKER = `SIG_VAL_MAKER,
  parameter SIG_SITE  = `SIG_VAL_SITE,
  parameter SIG_PART  = `SIG_VAL_PART
) (
  // clock and reset
  input  wire              mclk,
  input  wire              rst,
  // nonvolatile configuration, from outside the clock domain
  input  wire              lock_bit_first,
  input  wire              lock_bit_second,
  input  wire              lock_bit_third,
  input  wire              enc_programmed,
  input  wire              external_access_select,
  // programming system requests
  input  wire              prog_rd,
  input  wire              prog_sig,
  input  wire              prog_wr,
  input  wire              prog_enc_wr,
  input  wire [ADDR_W-1:0] prog_addr,
  input  wire [7:0]        prog_wdata,
  // programming system answers
  output reg  [7:0]        verify_data,
  output reg               verify_valid,
  output reg               verify_refused,
  output reg               prog_done,
  output reg               prog_refused,
  // code memory array
  output reg  [ADDR_W-1:0] mem_addr,
  output reg               mem_rd,
  output reg               mem_wr,
  output reg  [7:0]        mem_wdata,
  input  wire [7:0]        mem_rdata,
  // cpu side checks
  input  wire              cpu_code_table_read_instruction,
  input  wire [ADDR_W-1:0] cpu_code_table_read_instruction_addr,
  input  wire              cpu_exec_external,
  input  wire              cpu_ext_fetch,
  output reg               code_table_read_instruction_grant,
  output reg               code_table_read_instruction_block,
  output reg               ext_fetch_grant,
  output reg               ext_fetch_block,
  output reg               ea_effective,
  // register port
  input  wire [3:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata
);

  localparam IDX_W = `ENC_IDX_W;

  // verify pipeline states
  localparam VS_IDLE = 2'b00;
  localparam VS_MEM  = 2'b01;
  localparam VS_DATA = 2'b10;

  // level decode; undefined patterns fall through to the default
  function [1:0] lock_level;
    input b1;
    input b2;
    input b3;
    begin
      case ({b1, b2, b3})
        3'b000:  lock_level = `LVL_1;
        3'b100:  lock_level = `LVL_2;
        3'b110:  lock_level = `LVL_3;
        3'b111:  lock_level = `LVL_4;
        // undefined patterns are treated as the strictest level
        default: lock_level = `LVL_4;
      endcase
    end
  endfunction

  wire [4:0]  cfg_sync;
  wire        ea_pin_sync;
  reg  [1:0]  lock_q;
  reg         enc_q;
  reg  [1:0]  level_q;
  reg         undef_q;
  reg         ea_latched_q;
  reg  [1:0]  vstate_q;
  reg         vsig_q;
  reg  [7:0]  vsig_data_q;
  reg  [IDX_W-1:0] venc_idx_q;
  reg  [3:0]  flags_q;
  reg  [7:0]  ctrl_q;
  reg  [CNT_W-1:0] prog_rej_cnt_q;
  reg  [CNT_W-1:0] vfy_rej_cnt_q;
  reg  [CNT_W-1:0] code_table_read_instruction_rej_cnt_q;
  reg  [CNT_W-1:0] ext_rej_cnt_q;
  reg  [ADDR_W-1:0] last_addr_q;
  reg  [7:0]  rd_mux;
  wire [7:0]  scrambled;
  wire        lvl2_up;
  wire        lvl3_up;
  wire        lvl4;
  wire        enc_load;
  wire        prog_ok;
  wire        vfy_ok;
  wire        code_table_read_instruction_int;
  wire        code_table_read_instruction_deny;
  wire        ext_deny;
  wire        cnt_clr;
  wire        cnt_en;
  wire [3:0]  flag_set;

  // nonvolatile bits come from another domain
  sync_two_stage #(
    .WIDTH (5)
  ) u_cfg_sync (
    .mclk     (mclk),
    .rst      (1'b0),
    .async_in ({lock_bit_first, lock_bit_second, lock_bit_third,
                enc_programmed, external_access_select}),
    .sync_out (cfg_sync)
  );

  assign ea_pin_sync = cfg_sync[0];

  // sampled while rst is high; hold rst at least three cycles so the
  // synchroniser has settled before the last sample is taken
  always @(posedge mclk) begin
    if (rst) begin
      lock_q       <= cfg_sync[3:2];
      enc_q        <= cfg_sync[1];
      level_q      <= lock_level(cfg_sync[4], cfg_sync[3], cfg_sync[2]);
      undef_q      <= (lock_level(cfg_sync[4], cfg_sync[3], cfg_sync[2]) == `LVL_4) &&
                      (cfg_sync[4:2] != 3'b111);
      ea_latched_q <= ea_pin_sync;
    end
  end

  assign lvl2_up = (level_q != `LVL_1);
  assign lvl3_up = (level_q == `LVL_3) || (level_q == `LVL_4);
  assign lvl4    = (level_q == `LVL_4);

  // effective external-access select
  always @(posedge mclk) begin
    if (rst) begin
      ea_effective <= 1'b0;
    end else if (lvl2_up) begin
      ea_effective <= ea_latched_q;
    end else begin
      ea_effective <= ea_pin_sync;
    end
  end

  // programming of code memory and key table
  assign prog_ok  = ~lvl2_up;
  assign enc_load = prog_enc_wr & prog_ok;

  always @(posedge mclk) begin
    if (rst) begin
      mem_wr       <= 1'b0;
      mem_wdata    <= 8'h00;
      prog_done    <= 1'b0;
      prog_refused <= 1'b0;
    end else begin
      mem_wr       <= prog_wr & prog_ok;
      mem_wdata    <= prog_wr ? prog_wdata : mem_wdata;
      prog_done    <= (prog_wr | prog_enc_wr) & prog_ok;
      prog_refused <= (prog_wr | prog_enc_wr) & ~prog_ok;
    end
  end

  encryption_table #(
    .DEPTH (`ENC_DEPTH),
    .IDX_W (IDX_W)
  ) u_enc (
    .mclk       (mclk),
    .load_en    (enc_load),
    .load_idx   (prog_addr[IDX_W-1:0]),
    .load_data  (prog_wdata),
    .enc_active (enc_q),
    .sel_idx    (venc_idx_q),
    .plain_in   (mem_rdata),
    .scrambled  (scrambled)
  );

  // verify path: lock bits two and three both clear
  assign vfy_ok = ~lock_q[1] & ~lock_q[0] & ~lvl3_up;

  always @(posedge mclk) begin
    if (rst) begin
      vstate_q       <= VS_IDLE;
      vsig_q         <= 1'b0;
      vsig_data_q    <= 8'h00;
      venc_idx_q     <= {IDX_W{1'b0}};
      mem_addr       <= {ADDR_W{1'b0}};
      mem_rd         <= 1'b0;
      verify_data    <= 8'h00;
      verify_valid   <= 1'b0;
      verify_refused <= 1'b0;
    end else begin
      mem_rd         <= 1'b0;
      verify_valid   <= 1'b0;
      verify_refused <= 1'b0;
      case (vstate_q)
        VS_IDLE: begin
          if (prog_rd && prog_sig) begin
            vsig_q   <= 1'b1;
            vstate_q <= VS_MEM;
            case (prog_addr)
              `SIG_ADDR_MAKER: vsig_data_q <= SIG_MAKER;
              `SIG_ADDR_SITE:  vsig_data_q <= SIG_SITE;
              `SIG_ADDR_PART:  vsig_data_q <= SIG_PART;
              default:         vsig_data_q <= 8'h00;
            endcase
          end else if (prog_rd && vfy_ok) begin
            vsig_q     <= 1'b0;
            mem_addr   <= prog_addr;
            mem_rd     <= 1'b1;
            venc_idx_q <= prog_addr[IDX_W-1:0];
            vstate_q   <= VS_MEM;
          end else if (prog_rd) begin
            verify_data    <= 8'h00;
            verify_refused <= 1'b1;
          end
        end
        VS_MEM: begin
          vstate_q <= VS_DATA;
        end
        VS_DATA: begin
          // key byte never reaches this port on its own
          verify_data  <= vsig_q ? vsig_data_q : scrambled;
          verify_valid <= 1'b1;
          vstate_q     <= VS_IDLE;
        end
        default: begin
          vstate_q <= VS_IDLE;
        end
      endcase
    end
  end

  // table reads from external code into internal memory
  assign code_table_read_instruction_int      = ea_effective && ({1'b0, cpu_code_table_read_instruction_addr} < `INT_MEM_BYTES);
  assign code_table_read_instruction_deny     = cpu_code_table_read_instruction & cpu_exec_external & code_table_read_instruction_int & lvl2_up;
  assign ext_deny      = cpu_ext_fetch & lvl4;

  always @(posedge mclk) begin
    if (rst) begin
      code_table_read_instruction_grant      <= 1'b0;
      code_table_read_instruction_block      <= 1'b0;
      ext_fetch_grant <= 1'b0;
      ext_fetch_block <= 1'b0;
    end else begin
      code_table_read_instruction_grant      <= cpu_code_table_read_instruction & ~code_table_read_instruction_deny;
      code_table_read_instruction_block      <= code_table_read_instruction_deny;
      ext_fetch_grant <= cpu_ext_fetch & ~ext_deny;
      ext_fetch_block <= ext_deny;
    end
  end

  // sticky violation flags, write one to clear, a new event wins
  assign flag_set[`FL_PROG_REJ] = (prog_wr | prog_enc_wr) & ~prog_ok;
  assign flag_set[`FL_VFY_REJ]  = prog_rd & ~prog_sig & ~vfy_ok & (vstate_q == VS_IDLE);
  assign flag_set[`FL_CODE_TABLE_READ_INSTRUCTION_REJ] = code_table_read_instruction_deny;
  assign flag_set[`FL_EXT_REJ]  = ext_deny;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_flag
      always @(posedge mclk) begin
        if (rst) begin
          flags_q[g] <= 1'b0;
        end else if (flag_set[g]) begin
          flags_q[g] <= 1'b1;
        end else if (reg_wr && reg_addr == `REG_FLAGS && reg_wdata[g]) begin
          flags_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // control register steers the rejection counters
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `CTRL_RESET_VAL;
    end else if (reg_wr && reg_addr == `REG_CTRL) begin
      ctrl_q <= reg_wdata;
    end else begin
      ctrl_q[`CTRL_CNT_CLR] <= 1'b0;
    end
  end

  assign cnt_clr = ctrl_q[`CTRL_CNT_CLR];
  assign cnt_en  = ctrl_q[`CTRL_CNT_EN];

  // counters saturate so a flood of attempts never wraps to zero
  always @(posedge mclk) begin
    if (rst || cnt_clr) begin
      prog_rej_cnt_q <= {CNT_W{1'b0}};
      vfy_rej_cnt_q  <= {CNT_W{1'b0}};
      code_table_read_instruction_rej_cnt_q <= {CNT_W{1'b0}};
      ext_rej_cnt_q  <= {CNT_W{1'b0}};
    end else if (cnt_en) begin
      if (flag_set[`FL_PROG_REJ] && ~&prog_rej_cnt_q) begin
        prog_rej_cnt_q <= prog_rej_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (flag_set[`FL_VFY_REJ] && ~&vfy_rej_cnt_q) begin
        vfy_rej_cnt_q <= vfy_rej_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (flag_set[`FL_CODE_TABLE_READ_INSTRUCTION_REJ] && ~&code_table_read_instruction_rej_cnt_q) begin
        code_table_read_instruction_rej_cnt_q <= code_table_read_instruction_rej_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (flag_set[`FL_EXT_REJ] && ~&ext_rej_cnt_q) begin
        ext_rej_cnt_q <= ext_rej_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // address of the last refused programming or verify attempt
  always @(posedge mclk) begin
    if (rst) begin
      last_addr_q <= {ADDR_W{1'b0}};
    end else if (flag_set[`FL_PROG_REJ] || flag_set[`FL_VFY_REJ]) begin
      last_addr_q <= prog_addr;
    end
  end

  // read mux; nothing here reaches the key table
  always @* begin
    case (reg_addr)
      `REG_STATUS:       rd_mux = {3'b000, undef_q, enc_q, ea_effective, level_q};
      `REG_FLAGS:        rd_mux = {4'h0, flags_q};
      `REG_CTRL:         rd_mux = ctrl_q;
      `REG_PROG_REJ_CNT: rd_mux = prog_rej_cnt_q[7:0];
      `REG_VFY_REJ_CNT:  rd_mux = vfy_rej_cnt_q[7:0];
      `REG_CODE_TABLE_READ_INSTRUCTION_REJ_CNT: rd_mux = code_table_read_instruction_rej_cnt_q[7:0];
      `REG_EXT_REJ_CNT:  rd_mux = ext_rej_cnt_q[7:0];
      `REG_LAST_ADDR_LO: rd_mux = last_addr_q[7:0];
      `REG_LAST_ADDR_HI: rd_mux = last_addr_q[15:8];
      default:           rd_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

//--- test/code_array_model.sv
`timescale 1ns/100ps
module code_array_model (
  // clock
  input  wire logic        mclk,
  // array port
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [15:0] prog_addr,
  output logic      [7:0]  mem_rdata
);
  logic [7:0]  arr [0:65535];
  logic [15:0] wa_q;

  initial begin
    for (int i = 0; i < 65536; i++) arr[i] = i[7:0] ^ 8'h5c;
    mem_rdata = 8'h00;
  end

  // write address is the request address one cycle late, the block gives none
  // read data only in the cycle after the read, a toggling pattern otherwise
  always @(posedge mclk) begin
    wa_q <= prog_addr;
    if (mem_wr) arr[wa_q] <= mem_wdata;
    mem_rdata <= mem_rd ? arr[mem_addr] : ~mem_rdata;
  end
endmodule

//--- test/code_memory_lock_and_verify_chk.sv
`timescale 1ns/100ps
`include "code_lock_consts.vh"
module code_lock_chk #(
  parameter ADDR_W    = 16,
  parameter SIG_MAKER = `SIG_VAL_MAKER,
  parameter SIG_PART  = `SIG_VAL_PART
) (
  // clock, reset, lock pins
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              lock_bit_first,
  input  wire logic              lock_bit_second,
  input  wire logic              lock_bit_third,
  // programming side
  input  wire logic              prog_rd,
  input  wire logic              prog_sig,
  input  wire logic              prog_wr,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [7:0]        prog_wdata,
  input  wire logic [7:0]        verify_data,
  input  wire logic              verify_valid,
  input  wire logic              verify_refused,
  input  wire logic              prog_done,
  input  wire logic              prog_refused,
  input  wire logic              mem_wr,
  input  wire logic [7:0]        mem_wdata,
  // cpu side
  input  wire logic              cpu_code_table_read_instruction,
  input  wire logic [ADDR_W-1:0] cpu_code_table_read_instruction_addr,
  input  wire logic              cpu_exec_external,
  input  wire logic              cpu_ext_fetch,
  input  wire logic              code_table_read_instruction_grant,
  input  wire logic              code_table_read_instruction_block,
  input  wire logic              ext_fetch_grant,
  input  wire logic              ext_fetch_block,
  input  wire logic              ea_effective
);
  // lock pattern as seen at the last reset edge; pins may move later
  logic [2:0] lk_q;
  always @(posedge mclk) begin
    if (rst) lk_q <= {lock_bit_third, lock_bit_second, lock_bit_first};
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sig_maker_a: assert property (
    prog_rd && prog_sig && prog_addr == `SIG_ADDR_MAKER |-> ##3 verify_valid && verify_data == SIG_MAKER)
    else $error("maker signature wrong");
  sig_part_a: assert property (
    prog_rd && prog_sig && prog_addr == `SIG_ADDR_PART |-> ##3 verify_valid && verify_data == SIG_PART)
    else $error("part signature wrong");
  verify_open_a: assert property (
    prog_rd && !prog_sig && lk_q[2:1] == 2'b00 |=> !verify_refused ##2 verify_valid)
    else $error("verify not answered");
  verify_shut_a: assert property (
    prog_rd && !prog_sig && lk_q[2:1] != 2'b00 |=> verify_refused && verify_data == 8'h00)
    else $error("verify not refused");
  prog_reject_a: assert property (
    prog_wr && lk_q != 3'h0 |=> prog_refused && !mem_wr)
    else $error("program not rejected");
  prog_accept_a: assert property (
    prog_wr && lk_q == 3'h0 |=> prog_done && mem_wr && mem_wdata == $past(prog_wdata))
    else $error("program not accepted");
  code_table_read_instruction_block_a: assert property (
    cpu_code_table_read_instruction && cpu_exec_external && ea_effective && cpu_code_table_read_instruction_addr < 16'h4000 && lk_q != 3'h0
    |=> code_table_read_instruction_block && !code_table_read_instruction_grant)
    else $error("table read not blocked");
  code_table_read_instruction_open_a: assert property (
    cpu_code_table_read_instruction && lk_q == 3'h0 |=> code_table_read_instruction_grant && !code_table_read_instruction_block)
    else $error("table read not granted");
  ext_fetch_a: assert property (
    cpu_ext_fetch |=> ext_fetch_block == (lk_q == 3'h7) && ext_fetch_grant != ext_fetch_block)
    else $error("external fetch answer wrong");
  ea_frozen_a: assert property (
    lk_q != 3'h0 && !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> $stable(ea_effective))
    else $error("latched access select moved");
endmodule

bind code_memory_lock_and_verify code_lock_chk #(
  .ADDR_W(ADDR_W), .SIG_MAKER(SIG_MAKER), .SIG_PART(SIG_PART)
) i_chk (
  .mclk, .rst, .lock_bit_first, .lock_bit_second, .lock_bit_third, .prog_rd, .prog_sig,
  .prog_wr, .prog_addr, .prog_wdata, .verify_data, .verify_valid, .verify_refused,
  .prog_done, .prog_refused, .mem_wr, .mem_wdata, .cpu_code_table_read_instruction, .cpu_code_table_read_instruction_addr,
  .cpu_exec_external, .cpu_ext_fetch, .code_table_read_instruction_grant, .code_table_read_instruction_block, .ext_fetch_grant,
  .ext_fetch_block, .ea_effective
);

//--- test/code_memory_lock_and_verify_tb.sv
`timescale 1ns/100ps
`include "code_lock_consts.vh"
module code_memory_lock_and_verify_tb;
  // stimulus
  logic        mclk, rst, lock_bit_first, lock_bit_second, lock_bit_third;
  logic        enc_programmed, external_access_select, prog_rd, prog_sig, prog_wr;
  logic        prog_enc_wr, cpu_code_table_read_instruction, cpu_exec_external, cpu_ext_fetch, reg_wr, reg_rd;
  logic [15:0] prog_addr, cpu_code_table_read_instruction_addr, a;
  logic [7:0]  prog_wdata, reg_wdata;
  logic [3:0]  reg_addr;
  // responses
  logic [7:0]  verify_data, mem_wdata, mem_rdata, reg_rdata;
  logic [15:0] mem_addr;
  logic        verify_valid, verify_refused, prog_done, prog_refused, mem_rd, mem_wr;
  logic        code_table_read_instruction_grant, code_table_read_instruction_block, ext_fetch_grant, ext_fetch_block, ea_effective;
  // bench state
  int          error_cnt, check_count;
  logic [7:0]  key [0:31];
  localparam logic [15:0] WA = 16'h1234;
  localparam logic [7:0]  WD = 8'h9e;
  localparam logic [2:0]  pats [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
  localparam logic [15:0] sa [3] = '{`SIG_ADDR_MAKER, `SIG_ADDR_SITE, `SIG_ADDR_PART};
  localparam logic [7:0]  sv [3] = '{`SIG_VAL_MAKER, `SIG_VAL_SITE, `SIG_VAL_PART};

  code_memory_lock_and_verify i_dut (
    .mclk, .rst, .lock_bit_first, .lock_bit_second, .lock_bit_third, .enc_programmed,
    .external_access_select, .prog_rd, .prog_sig, .prog_wr, .prog_enc_wr, .prog_addr,
    .prog_wdata, .verify_data, .verify_valid, .verify_refused, .prog_done, .prog_refused,
    .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata, .cpu_code_table_read_instruction, .cpu_code_table_read_instruction_addr,
    .cpu_exec_external, .cpu_ext_fetch, .code_table_read_instruction_grant, .code_table_read_instruction_block, .ext_fetch_grant,
    .ext_fetch_block, .ea_effective, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata
  );
  code_array_model i_mem (.mclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .prog_addr, .mem_rdata);

  always #2 mclk = ~mclk;

  function automatic logic [7:0] vfy_exp(input logic [15:0] x, input logic e);
    logic [7:0] v;
    v = (x == WA) ? WD : (x[7:0] ^ 8'h5c);
    return e ? ~(v ^ key[x[4:0]]) : v;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // in this task config pins move inside reset so they settle through the synchronisers
  task automatic restart(input logic [2:0] lk, input logic enc, input logic ea);
    @(posedge mclk);
    rst <= 1'b1;
    {lock_bit_third, lock_bit_second, lock_bit_first} <= lk;
    enc_programmed <= enc;
    external_access_select <= ea;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
  endtask

  // k = {reg_rd, reg_wr, ext_fetch, code_table_read_instruction, enc_wr, prog_wr, sig, prog_rd}
  // three idle edges first keep every request clear of the busy window
  task automatic op(input logic [7:0] k, input logic [15:0] x, input logic [7:0] d);
    repeat (3) @(posedge mclk);
    prog_addr <= x;
    cpu_code_table_read_instruction_addr <= x;
    reg_addr <= x[3:0];
    prog_wdata <= d;
    reg_wdata <= d;
    {reg_rd, reg_wr, cpu_ext_fetch, cpu_code_table_read_instruction, prog_enc_wr, prog_wr, prog_sig, prog_rd} <= k;
    @(posedge mclk);
    {reg_rd, reg_wr, cpu_ext_fetch, cpu_code_table_read_instruction, prog_enc_wr, prog_wr, prog_sig, prog_rd} <= 8'h00;
    #1;
  endtask

  task automatic wait_vfy;
    for (int i = 0; i < 5 && verify_valid !== 1'b1 && verify_refused !== 1'b1; i++)
      @(posedge mclk) #1;
  endtask

  initial begin
    {mclk, lock_bit_first, lock_bit_second, lock_bit_third, enc_programmed} = '0;
    {external_access_select, prog_rd, prog_sig, prog_wr, prog_enc_wr, cpu_code_table_read_instruction} = '0;
    {cpu_exec_external, cpu_ext_fetch, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {prog_addr, cpu_code_table_read_instruction_addr, prog_wdata} = '0;
    rst = 1'b1;
    void'($urandom(32'hcd7e));
    restart(3'h0, 1'b0, 1'b1);
    for (int i = 0; i < 32; i++) begin
      key[i] = 8'($urandom);
      op(8'h08, 16'(i), key[i]);
      chk(prog_done, 1'b1);
    end
    op(8'h04, WA, WD);
    chk({mem_wr, mem_wdata}, {1'b1, WD});
    for (int l = 0; l < 4; l++) begin
      for (int e = 0; e < 2; e++) begin
        restart(pats[l], e[0], 1'b1);
        op(8'h80, `REG_STATUS, 8'h00);
        chk(reg_rdata, {4'h0, e[0], 1'b1, l[1:0]});
        @(posedge mclk);
        if (l == 0) {lock_bit_third, lock_bit_second, lock_bit_first} <= 3'h7;
        for (int j = 0; j < 3; j++) begin
          op(8'h03, sa[j], 8'h00);
          wait_vfy;
          chk({verify_valid, verify_data}, {1'b1, sv[j]});
        end
        for (int j = 0; j < 2; j++) begin
          a = j ? WA : (16'($urandom) & 16'h3fff);
          op(8'h01, a, 8'h00);
          wait_vfy;
          if (l > 1) chk({verify_refused, verify_data}, 9'h100);
          else chk({verify_valid, verify_data}, {1'b1, vfy_exp(a, e[0])});
        end
        op(8'h04, WA, WD);
        chk({prog_done, prog_refused, mem_wr}, l ? 3'b010 : 3'b101);
        a = 16'($urandom) & 16'h3fff;
        for (int j = 0; j < 3; j++) begin
          @(posedge mclk);
          cpu_exec_external <= (j != 2);
          op(8'h10, (j == 1) ? (a | 16'h4000) : a, 8'h00);
          chk({code_table_read_instruction_block, code_table_read_instruction_grant}, (l && j == 0) ? 2'b10 : 2'b01);
        end
        op(8'h20, 16'h0000, 8'h00);
        chk({ext_fetch_block, ext_fetch_grant}, (l == 3) ? 2'b10 : 2'b01);
        @(posedge mclk);
        external_access_select <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(ea_effective, l != 0);
        if (l == 3 && e == 1) begin
          op(8'h80, `REG_FLAGS, 8'h00);
          chk(reg_rdata, 8'h0f);
          op(8'h80, `REG_VFY_REJ_CNT, 8'h00);
          chk(reg_rdata, 8'h02);
          op(8'h40, `REG_FLAGS, 8'h0f);
          op(8'h80, `REG_FLAGS, 8'h00);
          chk(reg_rdata, 8'h00);
        end
      end
    end
    // third bit alone is no defined level: acts as level 4 and flags it
    restart(3'h4, 1'b0, 1'b1);
    op(8'h80, `REG_STATUS, 8'h00);
    chk(reg_rdata, 8'h17);
    for (int r = 9; r < 16; r++) begin
      op(8'h80, 16'(r), 8'h00);
      chk(reg_rdata, 8'h00);
    end
    wrap_up;
  end

  // whole run is near 775 cycles; this allows ample margin
  initial begin
    #60000;
    error_cnt++;
    wrap_up;
  end
endmodule
